/* src/sdx_pkg.sv */
// Purpose: Shared constants and types of the serial D/A and expander port
// Assumes: 16-bit command word, channel select in the low nibble
// Notes:   Channel index is zero based here (channel 1 is index 0)
package sdx_pkg;

  localparam int          SDX_NUM_CH       = 12;
  localparam int          SDX_WORD_W       = 16;
  localparam int          SDX_PIN_LSB      = 4;

  // Channel select codes
  localparam logic [3:0]  SDX_SEL_SPECIAL  = 4'h0;
  localparam logic [3:0]  SDX_SEL_CH_FIRST = 4'h1;
  localparam logic [3:0]  SDX_SEL_CH_LAST  = 4'hc;
  localparam logic [3:0]  SDX_SEL_S2P      = 4'hd;
  localparam logic [3:0]  SDX_SEL_P2S      = 4'he;
  localparam logic [3:0]  SDX_SEL_DIR      = 4'hf;

  // Sub-codes in word bits 7..4
  localparam logic [3:0]  SDX_SUB_LEVEL    = 4'h0;
  localparam logic [3:0]  SDX_SUB_HIZ      = 4'h1;
  localparam logic [3:0]  SDX_SUB_ALL_LVL  = 4'hc;
  localparam logic [3:0]  SDX_SUB_ALL_HIZ  = 4'hd;
  localparam logic [3:0]  SDX_SUB_RESET    = 4'he;

  // First channel index that shares a pin with the expander
  localparam logic [3:0]  SDX_FIRST_DUAL   = 4'h4;

  // Reset values
  localparam logic [7:0]  SDX_LEVEL_RESET  = 8'h00;
  localparam logic [11:0] SDX_DIR_RESET    = 12'h000;
  localparam logic [11:0] SDX_POUT_RESET   = 12'h000;
  localparam logic [11:0] SDX_ANA_RESET    = 12'h00f;
  localparam logic [15:0] SDX_SHIFT_RESET  = 16'h0000;

  typedef struct packed {
    logic [7:0] data;
    logic [3:0] sub;
    logic [3:0] sel;
  } sdx_word_t;

  typedef logic [SDX_NUM_CH-1:0][7:0] sdx_levels_t;

  typedef struct packed {
    logic [11:0] out;
    logic [11:0] oe_n;
  } sdx_pins_t;

  // Pin number of a dual-purpose channel (index 4 -> pin 11)
  function automatic logic [3:0] sdx_dual_pin(input logic [3:0] ch);
    sdx_dual_pin = 4'(4'hf - ch);
  endfunction : sdx_dual_pin

  // Pins that read as zero on capture: outputs and live analog pins
  function automatic logic [11:0] sdx_cap_block(input logic [11:0] dir,
                                                input logic [11:0] ana);
    logic [11:0] m;
    m = dir;
    for (int c = 4; c < 12; c++)
    begin
      m[15-c] = m[15-c] | ana[c];
    end
    sdx_cap_block = m;
  endfunction : sdx_cap_block

  // Channel drives its analog level when enabled and its pin is no output
  function automatic logic [11:0] sdx_ana_live(input logic [11:0] dir,
                                               input logic [11:0] ana);
    logic [11:0] m;
    m = ana;
    for (int c = 4; c < 12; c++)
    begin
      m[c] = ana[c] & ~dir[15-c];
    end
    sdx_ana_live = m;
  endfunction : sdx_ana_live

endpackage : sdx_pkg

/* src/sdx_sync2.sv */
// Purpose: Two flip-flop synchroniser for a bundle of levels
// Assumes: Each bit is an independent slow level
// Notes:   The first stage is read by the second stage only
`timescale 1ns/1ps
module sdx_sync2 #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : sdx_sync2

/* src/sdx_command_port.sv */
// Purpose: Command port of a 12-channel 8-bit D/A with 12-bit expander
// Assumes: Shift clock stands still while chip select is high
// Notes on behaviour
// - Shift serial input on rising shift clock
// - Frames are 16-bit words in shift register
// - Serial out shows bit 0, falling edge
// - Serial out floats while chip select high
// - Select low frames, rising select executes word
// - Low nibble selects the function
// - Sub-code 0 loads channel level
// - Sub-code 1 floats dual channels 5-12
// - Broadcast sub-code C loads all levels
// - Broadcast sub-code D floats channels 5-12
// - Broadcast sub-code E restores power-on levels, enables, direction, upper shift
// - Serial-to-parallel drives output-marked pins
// - Parallel-to-serial captures pins into bits 15..4
// - Output or analog pins capture as zero
// - Direction write: one output, zero input
// - Power-on: channels 1-4 at zero, pins float
// - Power-on clears levels, direction, upper shift
// - Direction bit overrides, earlier state returns
// - Level command revives floated channel
`timescale 1ns/1ps
module sdx_command_port (
  // System clock and power-on reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Serial link
  input  wire logic                 shift_clk,
  input  wire logic                 cs_n,
  input  wire logic                 ser_in,
  output logic                      ser_out,
  output logic                      ser_out_oe_n,
  // Expander pins
  input  wire logic [11:0]          expander_pin_in,
  output sdx_pkg::sdx_pins_t        expander_pin,
  // Analog channels
  output sdx_pkg::sdx_levels_t      analog_out_channel,
  output logic      [11:0]          analog_out_live,
  output logic      [11:0]          pin_direction
);
  import sdx_pkg::*;

  // Link domain state
  logic [15:0]  shift_reg;
  logic [15:0]  shift_next;
  logic         first_reg;
  logic         so_reg;

  // System domain state
  sdx_levels_t  level_reg;
  sdx_levels_t  level_next;
  logic [11:0]  ana_reg;
  logic [11:0]  ana_next;
  logic [11:0]  pin_direction_register;
  logic [11:0]  dir_next;
  logic [11:0]  pout_reg;
  logic [11:0]  pout_next;
  logic [15:0]  pre_reg;
  logic [15:0]  pre_next;
  logic         pre_v_reg;
  logic         pre_v_next;
  logic         cs_prev_reg;

  // Synchronised pins
  logic         cs_s;
  logic [11:0]  pin_s;

  sdx_sync2 #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_cs_sync (
    .clk (ref_clk),
    .rst (rst),
    .d   (cs_n),
    .q   (cs_s)
  );

  sdx_sync2 #(
    .W       (12),
    .RST_VAL (12'h000)
  ) u_pin_sync (
    .clk (ref_clk),
    .rst (rst),
    .d   (expander_pin_in),
    .q   (pin_s)
  );

  // Link side: preload from the last command enters at the first edge
  wire  [15:0]  shift_base = (first_reg && pre_v_reg) ? pre_reg : shift_reg;

  assign shift_next = {ser_in, shift_base[15:1]};

  always_ff @(posedge shift_clk or posedge rst)
  begin
    if (rst)
      shift_reg <= SDX_SHIFT_RESET;
    else if (!cs_n)
      shift_reg <= shift_next;
  end

  // Marks the first shift edge of a frame; set while select is high
  always_ff @(posedge shift_clk or posedge cs_n)
  begin
    if (cs_n)
      first_reg <= 1'b1;
    else
      first_reg <= 1'b0;
  end

  always_ff @(negedge shift_clk or posedge rst)
  begin
    if (rst)
      so_reg <= 1'b0;
    else
      so_reg <= shift_reg[0];
  end

  assign ser_out      = so_reg;
  assign ser_out_oe_n = cs_n;

  // System side: execute on synchronised rising select
  wire          exec_w  = cs_s & ~cs_prev_reg;
  sdx_word_t    word_w;
  assign        word_w  = sdx_word_t'(shift_reg);
  wire  [11:0]  field_w = shift_reg[15:SDX_PIN_LSB];
  wire          is_ch_w = (word_w.sel >= SDX_SEL_CH_FIRST) &&
                          (word_w.sel <= SDX_SEL_CH_LAST);
  wire  [3:0]   ch_w    = 4'(word_w.sel - SDX_SEL_CH_FIRST);
  wire          dual_w  = (ch_w >= SDX_FIRST_DUAL);
  wire  [11:0]  block_w = sdx_cap_block(pin_direction_register, ana_reg);
  wire  [11:0]  cap_w   = pin_s & ~block_w;

  always_comb
  begin
    level_next = level_reg;
    ana_next   = ana_reg;
    dir_next   = pin_direction_register;
    pout_next  = pout_reg;
    pre_next   = pre_reg;
    pre_v_next = pre_v_reg;
    if (exec_w)
    begin
      pre_v_next = 1'b0;
      case (word_w.sel)
        SDX_SEL_SPECIAL:
        begin
          case (word_w.sub)
            SDX_SUB_ALL_LVL:
            begin
              for (int i = 0; i < SDX_NUM_CH; i++)
              begin
                level_next[i] = word_w.data;
              end
              ana_next = '1;
            end
            SDX_SUB_ALL_HIZ:
            begin
              ana_next = ana_reg & SDX_ANA_RESET;
            end
            SDX_SUB_RESET:
            begin
              for (int i = 0; i < SDX_NUM_CH; i++)
              begin
                level_next[i] = SDX_LEVEL_RESET;
              end
              ana_next   = SDX_ANA_RESET;
              dir_next   = SDX_DIR_RESET;
              pre_next   = {SDX_LEVEL_RESET, shift_reg[7:0]};
              pre_v_next = 1'b1;
            end
            default:
            begin
            end
          endcase
        end
        SDX_SEL_S2P:
        begin
          pout_next = field_w;
        end
        SDX_SEL_P2S:
        begin
          pre_next   = {cap_w, shift_reg[3:0]};
          pre_v_next = 1'b1;
        end
        SDX_SEL_DIR:
        begin
          dir_next = field_w;
        end
        default:
        begin
          if (is_ch_w && word_w.sub == SDX_SUB_LEVEL)
          begin
            level_next[ch_w] = word_w.data;
            ana_next[ch_w]   = 1'b1;
          end
          else if (is_ch_w && word_w.sub == SDX_SUB_HIZ && dual_w)
          begin
            ana_next[ch_w] = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      level_reg              <= '0;
      ana_reg                <= SDX_ANA_RESET;
      pin_direction_register <= SDX_DIR_RESET;
      pout_reg               <= SDX_POUT_RESET;
      pre_reg                <= SDX_SHIFT_RESET;
      pre_v_reg              <= 1'b0;
      cs_prev_reg            <= 1'b1;
    end
    else
    begin
      level_reg              <= level_next;
      ana_reg                <= ana_next;
      pin_direction_register <= dir_next;
      pout_reg               <= pout_next;
      pre_reg                <= pre_next;
      pre_v_reg              <= pre_v_next;
      cs_prev_reg            <= cs_s;
    end
  end

  // Direction decides drive; analog state is kept underneath it
  assign expander_pin.out   = pout_reg;
  assign expander_pin.oe_n  = ~pin_direction_register;
  assign analog_out_channel = level_reg;
  assign analog_out_live    = sdx_ana_live(pin_direction_register,
                                           ana_reg);
  assign pin_direction      = pin_direction_register;

  // Checks
  property p_shift_in;
    @(posedge shift_clk) disable iff (rst)
      !cs_n |=> shift_reg[15] == $past(ser_in);
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("serial bit not shifted into bit 15");

  property p_hold_high;
    @(posedge ref_clk) disable iff (rst)
      cs_n && $past(cs_n) |-> $stable(shift_reg);
  endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("shift register moved while deselected");

  property p_so_lsb;
    @(negedge shift_clk) disable iff (rst)
      1'b1 |=> so_reg == $past(shift_reg[0]);
  endproperty
  a_so_lsb: assert property (p_so_lsb)
    else $error("serial out is not the previous bit 0");

  property p_float;
    @(posedge ref_clk) disable iff (rst)
      cs_n |-> ser_out_oe_n;
  endproperty
  a_float: assert property (p_float)
    else $error("serial out driven while deselected");

  sequence s_cs_rise;
    !cs_s ##1 cs_s;
  endsequence

  property p_exec_once;
    @(posedge ref_clk) disable iff (rst)
      s_cs_rise |-> exec_w ##1 !exec_w;
  endproperty
  a_exec_once: assert property (p_exec_once)
    else $error("rising select did not execute exactly once");

  property p_level;
    @(posedge ref_clk) disable iff (rst)
      exec_w && is_ch_w && word_w.sub == SDX_SUB_LEVEL |=>
        level_reg[$past(ch_w)] == $past(word_w.data) &&
        ana_reg[$past(ch_w)];
  endproperty
  a_level: assert property (p_level)
    else $error("channel level not loaded");

  property p_hiz_ch;
    @(posedge ref_clk) disable iff (rst)
      exec_w && is_ch_w && word_w.sub == SDX_SUB_HIZ |=>
        ana_reg[$past(ch_w)] == ($past(ch_w) < SDX_FIRST_DUAL);
  endproperty
  a_hiz_ch: assert property (p_hiz_ch)
    else $error("channel float handled wrongly");

  property p_bcast;
    @(posedge ref_clk) disable iff (rst)
      exec_w && word_w.sel == SDX_SEL_SPECIAL &&
        word_w.sub == SDX_SUB_ALL_LVL |=>
        level_reg[0] == $past(word_w.data) &&
        level_reg[11] == $past(word_w.data) && ana_reg == 12'hfff;
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("broadcast level not applied");

  property p_all_hiz;
    @(posedge ref_clk) disable iff (rst)
      exec_w && word_w.sel == SDX_SEL_SPECIAL &&
        word_w.sub == SDX_SUB_ALL_HIZ |=> ana_reg[11:4] == 8'h00;
  endproperty
  a_all_hiz: assert property (p_all_hiz)
    else $error("dual channels not floated");

  property p_soft_reset;
    @(posedge ref_clk) disable iff (rst)
      exec_w && word_w.sel == SDX_SEL_SPECIAL &&
        word_w.sub == SDX_SUB_RESET |=>
        pin_direction_register == SDX_DIR_RESET &&
        ana_reg == SDX_ANA_RESET && level_reg == '0 &&
        pre_reg[15:8] == SDX_LEVEL_RESET && pre_v_reg;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("reset command did not restore power-on state");

  property p_s2p;
    @(posedge ref_clk) disable iff (rst)
      exec_w && word_w.sel == SDX_SEL_S2P |=>
        expander_pin.out == $past(field_w) &&
        $stable(pin_direction_register);
  endproperty
  a_s2p: assert property (p_s2p)
    else $error("parallel output not written");

  property p_p2s;
    @(posedge ref_clk) disable iff (rst)
      exec_w && word_w.sel == SDX_SEL_P2S |=>
        pre_v_reg && pre_reg[3:0] == $past(shift_reg[3:0]) &&
        (pre_reg[15:4] & $past(block_w)) == 12'h000;
  endproperty
  a_p2s: assert property (p_p2s)
    else $error("capture word wrong");

  property p_dir;
    @(posedge ref_clk) disable iff (rst)
      exec_w && word_w.sel == SDX_SEL_DIR |=>
        pin_direction_register == $past(field_w) &&
        expander_pin.oe_n == ~$past(field_w);
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction register not written");

endmodule : sdx_command_port

/* dv/sdx_host_model.sv */
// Purpose: Host side of the serial link, frames words bit 0 first
// Assumes: Link clock stands low while chip select is high
// Notes:   Read bits are sampled just before each rising shift clock
`timescale 1ns/1ps
module sdx_host_model (
  // Serial link
  output logic      shift_clk,
  output logic      cs_n,
  output logic      ser_in,
  input  wire logic ser_out,
  input  wire logic ser_out_oe_n
);
  // Released line shows the inverse of the last bit, so a float is caught
  logic so_line;
  assign so_line = ser_out_oe_n ? ~ser_out : ser_out;

  initial
  begin
    shift_clk = 1'b0;
    cs_n      = 1'b1;
    ser_in    = 1'b0;
  end

  // Sends pre junk bits, then the 16-bit word; rd[k-1] is seen at rise k
  task automatic frame(input logic [15:0] w, input int pre,
                       output logic [15:0] rd);
    int n;
    #7;
    cs_n = 1'b0;
    #40;
    for (n = 0; n < pre + 16; n++)
    begin
      ser_in = (n < pre) ? n[0] : w[n - pre];
      #15;
      if (n >= pre)
        rd[n - pre] = so_line;
      shift_clk = 1'b1;
      #15;
      shift_clk = 1'b0;
    end
    #40;
    cs_n   = 1'b1;
    ser_in = ~ser_in;
  endtask : frame
endmodule : sdx_host_model

/* dv/tb_top.sv */
// Purpose: Self-checking bench of the serial D/A and expander port
// Assumes: Registers settle within 6 reference cycles after a frame
// Notes:   Host model drives the link; bench owns reset and pins
`timescale 1ns/1ps
module tb_top;
  import sdx_pkg::*;
  logic        ref_clk;
  logic        rst;
  logic        shift_clk;
  logic        cs_n;
  logic        ser_in;
  logic        ser_out;
  logic        ser_out_oe_n;
  logic [11:0] expander_pin_in;
  logic [11:0] analog_out_live;
  logic [11:0] pin_direction;
  sdx_pins_t   expander_pin;
  sdx_levels_t analog_out_channel;
  logic [15:0] rd;
  int          fail_count;
  int          checks;

  always #10 ref_clk = ~ref_clk;

  sdx_command_port sdx_command_port_i (
    .ref_clk            (ref_clk),
    .rst                (rst),
    .shift_clk          (shift_clk),
    .cs_n               (cs_n),
    .ser_in             (ser_in),
    .ser_out            (ser_out),
    .ser_out_oe_n       (ser_out_oe_n),
    .expander_pin_in    (expander_pin_in),
    .expander_pin       (expander_pin),
    .analog_out_channel (analog_out_channel),
    .analog_out_live    (analog_out_live),
    .pin_direction      (pin_direction)
  );

  sdx_host_model sdx_host_model_i (
    .shift_clk    (shift_clk),
    .cs_n         (cs_n),
    .ser_in       (ser_in),
    .ser_out      (ser_out),
    .ser_out_oe_n (ser_out_oe_n)
  );

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task results;
    $display("Counts: checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task send(input logic [3:0] sel, input logic [3:0] sub,
            input logic [7:0] data, input int pre);
    sdx_host_model_i.frame({data, sub, sel}, pre, rd);
    repeat (6) @(posedge ref_clk);
    check(ser_out_oe_n, 1'b1);
  endtask : send

  task t_reset;
    int c;
    check(pin_direction, 12'h000);
    check(expander_pin.oe_n, 12'hfff);
    check(analog_out_live, 12'h00f);
    for (c = 0; c < 12; c++)
      check(analog_out_channel[c], 8'h00);
    $display("Test reset done");
  endtask : t_reset

  task t_level;
    logic [15:0] prev;
    int          c;
    prev = 16'h0000;
    for (c = 0; c < 12; c++)
    begin
      send(4'(c + 1), 4'h0, 8'(8'h11 * (c + 1)), 0);
      check(rd, prev);
      prev = {8'(8'h11 * (c + 1)), 4'h0, 4'(c + 1)};
    end
    for (c = 0; c < 12; c++)
      check(analog_out_channel[c], 8'(8'h11 * (c + 1)));
    send(4'h1, 4'h0, 8'h3c, 5);
    check(analog_out_channel[0], 8'h3c);
    send(4'h1, 4'h2, 8'hff, 0);
    check(analog_out_channel[0], 8'h3c);
    $display("Test level done");
  endtask : t_level

  task t_hiz;
    send(4'h5, 4'h1, 8'h00, 0);
    check(analog_out_live, 12'hfef);
    send(4'h1, 4'h1, 8'h00, 0);
    check(analog_out_live, 12'hfef);
    send(4'h5, 4'h0, 8'h77, 0);
    check(analog_out_live, 12'hfff);
    check(analog_out_channel[4], 8'h77);
    $display("Test float done");
  endtask : t_hiz

  task t_bcast;
    int c;
    send(4'h0, 4'hc, 8'h5a, 0);
    send(4'h0, 4'hb, 8'hff, 0);
    send(4'h0, 4'hf, 8'hff, 0);
    for (c = 0; c < 12; c++)
      check(analog_out_channel[c], 8'h5a);
    send(4'h0, 4'hd, 8'h00, 0);
    check(analog_out_live, 12'h00f);
    send(4'hf, 4'h0, 8'h0f, 0);
    check(pin_direction, 12'h0f0);
    send(4'h0, 4'he, 8'h00, 0);
    check(pin_direction, 12'h000);
    check(analog_out_live, 12'h00f);
    for (c = 0; c < 12; c++)
      check(analog_out_channel[c], 8'h00);
    $display("Test broadcast done");
  endtask : t_bcast

  task t_dir;
    send(4'h0, 4'hc, 8'h80, 0);
    send(4'hf, 4'hf, 8'hf0, 0);
    check(pin_direction, 12'hf0f);
    check(expander_pin.oe_n, 12'h0f0);
    check(analog_out_live, 12'hf0f);
    send(4'hd, 4'h6, 8'h9a, 0);
    check(expander_pin.out, 12'h9a6);
    send(4'hf, 4'h0, 8'h00, 0);
    check(analog_out_live, 12'hfff);
    check(expander_pin.oe_n, 12'hfff);
    $display("Test direction done");
  endtask : t_dir

  task t_p2s;
    @(posedge ref_clk);
    expander_pin_in <= 12'ha5f;
    send(4'h0, 4'hd, 8'h00, 0);
    send(4'hc, 4'h0, 8'h40, 0);
    check(analog_out_live, 12'h80f);
    send(4'hf, 4'h3, 8'h00, 0);
    send(4'he, 4'h0, 8'h00, 0);
    send(4'h0, 4'hf, 8'h00, 0);
    check(rd[15:4], 12'ha4c);
    $display("Test capture done");
  endtask : t_p2s

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    results();
  end

  initial
  begin
    ref_clk         = 1'b0;
    rst             = 1'b1;
    expander_pin_in = 12'h000;
    fail_count      = 0;
    checks          = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_level();
    t_hiz();
    t_bcast();
    t_dir();
    t_p2s();
    results();
  end
endmodule : tb_top
